// ===== hdl/qup_pkg.sv
package qup_pkg;

  // ----------------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------------
  localparam int QUP_CHAN_NUM = 4;
  localparam int QUP_ADDR_W = 3;
  localparam int QUP_DATA_W = 8;
  localparam int QUP_CHAN_W = 2;
  localparam int QUP_SYNC_STAGES = 2;

  // ----------------------------------------------------------------------
  // Layout of the synchronised pin vector
  // ----------------------------------------------------------------------
  localparam int QUP_PIN_DATA_LSB = 0;
  localparam int QUP_PIN_ADDR_LSB = 8;
  localparam int QUP_PIN_CS_LSB = 11;
  localparam int QUP_PIN_WR_BIT = 15;
  localparam int QUP_PIN_RD_BIT = 16;
  localparam int QUP_PIN_STYLE_BIT = 17;
  localparam int QUP_PIN_W = 18;

  // ----------------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------------
  localparam logic [QUP_PIN_W-1:0] QUP_PIN_RST = 18'h3f800;
  localparam logic [QUP_DATA_W-1:0] QUP_DATA_RST = 8'h00;
  localparam logic [QUP_ADDR_W-1:0] QUP_ADDR_RST = 3'h0;
  localparam logic [QUP_CHAN_W-1:0] QUP_CHAN_RST = 2'h0;

  typedef logic [QUP_CHAN_W-1:0] qup_chan_t;

endpackage : qup_pkg

// ===== hdl/qup_sync_if.sv
`timescale 1ns/1ps
`default_nettype none

interface qup_sync_if #(
  parameter int WIDTH = 1
);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] sync;

  modport src (output raw, input sync);
  modport dst (input raw, output sync);
endinterface : qup_sync_if

`default_nettype wire

// ===== hdl/qup_sync.sv
`timescale 1ns/1ps
`default_nettype none

module qup_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Pins in, stable copy out
  qup_sync_if.dst pins
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= pins.raw;
      sync_q <= meta_q;
    end
  end

  assign pins.sync = sync_q;

endmodule : qup_sync

`default_nettype wire

// ===== hdl/qup_host_port.sv
`timescale 1ns/1ps
`default_nettype none

module qup_host_port (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Host bus pins
  input wire logic bus_style_in,
  input wire logic read_strobe_n_in,
  input wire logic write_strobe_n_in,
  input wire logic chan_a_select_n_in,
  input wire logic chan_b_select_n_in,
  input wire logic chan_c_select_n_in,
  input wire logic chan_d_select_n_in,
  input wire logic [qup_pkg::QUP_ADDR_W-1:0] addr_in,
  input wire logic [qup_pkg::QUP_DATA_W-1:0] data_in,
  output logic [qup_pkg::QUP_DATA_W-1:0] data_out,
  output logic data_oe_out,
  // Interrupt and ready pins
  output logic [qup_pkg::QUP_CHAN_NUM-1:0] chan_irq_out,
  output logic [qup_pkg::QUP_CHAN_NUM-1:0] chan_irq_oe_out,
  output logic tx_ready_summary_n_out,
  output logic rx_ready_summary_n_out,
  // Channel register access
  output logic reg_rd_out,
  output logic reg_wr_out,
  output logic [qup_pkg::QUP_CHAN_W-1:0] reg_chan_out,
  output logic [qup_pkg::QUP_ADDR_W-1:0] reg_addr_out,
  output logic [qup_pkg::QUP_DATA_W-1:0] reg_wdata_out,
  input wire logic [qup_pkg::QUP_DATA_W-1:0] reg_rdata_in,
  // Channel status
  input wire logic [qup_pkg::QUP_CHAN_NUM-1:0] chan_irq_in,
  input wire logic [qup_pkg::QUP_CHAN_NUM-1:0] irq_output_drive_bit_in,
  input wire logic [qup_pkg::QUP_CHAN_NUM-1:0] tx_ready_n_in,
  input wire logic [qup_pkg::QUP_CHAN_NUM-1:0] rx_ready_n_in
);
  import qup_pkg::*;

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  qup_sync_if #(.WIDTH(QUP_PIN_W)) pin_if ();

  assign pin_if.raw = {bus_style_in, read_strobe_n_in, write_strobe_n_in,
                       chan_d_select_n_in, chan_c_select_n_in,
                       chan_b_select_n_in, chan_a_select_n_in,
                       addr_in, data_in};

  qup_sync #(.WIDTH(QUP_PIN_W), .RST_VAL(QUP_PIN_RST)) u_sync (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .pins(pin_if)
  );

  // Previous sample, so edges and the values before them are both visible
  logic [QUP_PIN_W-1:0] prev_q;

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      prev_q <= QUP_PIN_RST;
    end else begin
      prev_q <= pin_if.sync;
    end
  end

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  // In strobe style the lowest active select wins when the host asserts several at once
  function automatic qup_chan_t qup_chan_of(input logic style,
                                            input logic [3:0] cs_n);
    qup_chan_t chan;
    chan = QUP_CHAN_RST;
    if (!style) begin
      chan = {cs_n[2], cs_n[1]};
    end else if (!cs_n[0]) begin
      chan = 2'h0;
    end else if (!cs_n[1]) begin
      chan = 2'h1;
    end else if (!cs_n[2]) begin
      chan = 2'h2;
    end else begin
      chan = 2'h3;
    end
    return chan;
  endfunction : qup_chan_of

  // Read and write request levels for one pin sample
  function automatic logic [1:0] qup_req_of(input logic [QUP_PIN_W-1:0] s);
    logic sel;
    logic [1:0] req;
    sel = 1'b0;
    req = 2'h0;
    if (s[QUP_PIN_STYLE_BIT]) begin
      sel = ~&s[QUP_PIN_CS_LSB +: 4];
      req = {sel & ~s[QUP_PIN_RD_BIT], sel & ~s[QUP_PIN_WR_BIT]};
    end else begin
      sel = ~s[QUP_PIN_CS_LSB];
      // Read strobe pin deliberately not looked at here
      req = {sel & s[QUP_PIN_WR_BIT], sel & ~s[QUP_PIN_WR_BIT]};
    end
    return req;
  endfunction : qup_req_of

  logic [1:0] req_now;
  logic [1:0] req_prev;
  logic rd_start;
  logic wr_commit;
  logic style_s;

  assign style_s = pin_if.sync[QUP_PIN_STYLE_BIT];
  assign req_now = qup_req_of(pin_if.sync);
  assign req_prev = qup_req_of(prev_q);
  assign rd_start = req_now[1] & ~req_prev[1];
  // Write lands when the request level ends, using the values just before unless a read starts in the same cycle
  assign wr_commit = req_prev[0] & ~req_now[0];

  // ----------------------------------------------------------------------
  // Register access strobes
  // ----------------------------------------------------------------------
  logic rd_q;
  logic wr_q;
  qup_chan_t chan_q;
  logic [QUP_ADDR_W-1:0] addr_q;
  logic [QUP_DATA_W-1:0] wdata_q;

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      chan_q <= QUP_CHAN_RST;
      addr_q <= QUP_ADDR_RST;
      wdata_q <= QUP_DATA_RST;
    end else begin
      rd_q <= rd_start;
      wr_q <= wr_commit;
      if (rd_start) begin
        chan_q <= qup_chan_of(style_s, pin_if.sync[QUP_PIN_CS_LSB +: 4]);
        addr_q <= pin_if.sync[QUP_PIN_ADDR_LSB +: QUP_ADDR_W];
      end else if (wr_commit) begin
        chan_q <= qup_chan_of(prev_q[QUP_PIN_STYLE_BIT],
                              prev_q[QUP_PIN_CS_LSB +: 4]);
        addr_q <= prev_q[QUP_PIN_ADDR_LSB +: QUP_ADDR_W];
        wdata_q <= prev_q[QUP_PIN_DATA_LSB +: QUP_DATA_W];
      end
    end
  end

  assign reg_rd_out = rd_q;
  assign reg_wr_out = wr_q;
  assign reg_chan_out = chan_q;
  assign reg_addr_out = addr_q;
  assign reg_wdata_out = wdata_q;

  // ----------------------------------------------------------------------
  // Read data drive
  // ----------------------------------------------------------------------
  logic [QUP_DATA_W-1:0] dout_q;
  logic doe_q;

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      dout_q <= QUP_DATA_RST;
    end else if (rd_q) begin
      dout_q <= reg_rdata_in;
    end
  end

  // Bus released on the clock after the synchronised read level drops, to avoid contention
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      doe_q <= 1'b0;
    end else begin
      doe_q <= req_now[1] & ~rd_start;
    end
  end

  assign data_out = dout_q;
  assign data_oe_out = doe_q;

  // ----------------------------------------------------------------------
  // Interrupt pins
  // ----------------------------------------------------------------------
  logic [3:0] irq_q;
  logic [3:0] irq_oe_q;

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_q <= 4'h0;
      irq_oe_q <= 4'h0;
    end else if (style_s) begin
      irq_q <= chan_irq_in;
      irq_oe_q <= irq_output_drive_bit_in;
    end else begin
      // Bit 0 open drain: pulls low while any channel interrupt is up, a pull-up gives the high level; bits 3:1 always drive low
      irq_q <= 4'h0;
      irq_oe_q <= {3'h7, |chan_irq_in};
    end
  end

  assign chan_irq_out = irq_q;
  assign chan_irq_oe_out = irq_oe_q;

  // ----------------------------------------------------------------------
  // Ready summaries
  // ----------------------------------------------------------------------
  logic tx_sum_q;
  logic rx_sum_q;

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_sum_q <= 1'b1;
      rx_sum_q <= 1'b1;
    end else begin
      tx_sum_q <= &tx_ready_n_in;
      rx_sum_q <= &rx_ready_n_in;
    end
  end

  assign tx_ready_summary_n_out = tx_sum_q;
  assign rx_ready_summary_n_out = rx_sum_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  logic [3:0] cs_s;
  assign cs_s = pin_if.sync[QUP_PIN_CS_LSB +: 4];

  AST_RD_PULSE: assert property (rd_start |=> reg_rd_out ##1 !reg_rd_out)
    else $error("read start not followed by one-cycle read pulse");
  AST_RD_DATA: assert property (
    reg_rd_out |=> data_out == $past(reg_rdata_in))
    else $error("read byte not placed on the data bus");
  AST_WR_DATA: assert property (wr_commit |=> reg_wr_out &&
    reg_wdata_out == $past(prev_q[QUP_PIN_DATA_LSB +: QUP_DATA_W]))
    else $error("write byte not stored at end of write");
  AST_RW_DIR: assert property (
    (!style_s && reg_rd_out) |-> $past(pin_if.sync[QUP_PIN_WR_BIT]))
    else $error("read/write style read without direction high");
  AST_CS_IDLE: assert property (
    (&cs_s && &prev_q[QUP_PIN_CS_LSB +: 4]) |=> !reg_rd_out && !reg_wr_out)
    else $error("access without any chip select");
  AST_RW_CHAN: assert property (
    (!style_s && rd_start) |=> reg_chan_out == $past({cs_s[2], cs_s[1]}))
    else $error("channel address decode wrong");
  AST_IRQ_STROBE: assert property (
    style_s |=> chan_irq_oe_out == $past(irq_output_drive_bit_in))
    else $error("interrupt drive enable wrong in strobe style");
  AST_IRQ_RW: assert property (!style_s |=> chan_irq_out == 4'h0 &&
    chan_irq_oe_out == {3'h7, $past(|chan_irq_in)})
    else $error("interrupt pins wrong in read/write style");
  AST_RDY: assert property (##1 tx_ready_summary_n_out ==
    $past(&tx_ready_n_in) && rx_ready_summary_n_out == $past(&rx_ready_n_in))
    else $error("ready summary not the AND of channel flags");

  COV_STROBE_RD: cover property (style_s && rd_start ##2 data_oe_out);
  COV_STROBE_WR: cover property (style_s ##0 wr_commit ##1 reg_wr_out);
  COV_RW_RD: cover property (!style_s && rd_start ##1 reg_chan_out == 2'h3);
  COV_RW_IRQ: cover property (!style_s && |chan_irq_in ##1 chan_irq_oe_out[0]);

endmodule : qup_host_port

`default_nettype wire

// ===== test/qup_regs_model.sv
`timescale 1ns/1ps
`default_nettype none

module qup_regs_model (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Register access from the port
  input wire logic reg_wr_in,
  input wire logic [qup_pkg::QUP_CHAN_W-1:0] reg_chan_in,
  input wire logic [qup_pkg::QUP_ADDR_W-1:0] reg_addr_in,
  input wire logic [qup_pkg::QUP_DATA_W-1:0] reg_wdata_in,
  output logic [qup_pkg::QUP_DATA_W-1:0] reg_rdata_out
);
  import qup_pkg::*;
  logic [QUP_DATA_W-1:0] mem_q [32];
  // ----------------------------------------------------------------------
  // Channel register banks
  // ----------------------------------------------------------------------
  // Same-clock answer: the port samples it with its read pulse
  assign reg_rdata_out = mem_q[{reg_chan_in, reg_addr_in}];
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < 32; i++) mem_q[i] <= 8'h00;
    end else if (reg_wr_in) begin
      mem_q[{reg_chan_in, reg_addr_in}] <= reg_wdata_in;
    end
  end
endmodule : qup_regs_model

`default_nettype wire

// ===== test/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  import qup_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic style = 1'b1;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic [3:0] cs_n = 4'hf;
  logic [2:0] addr = 3'h0;
  logic [7:0] din = 8'h00;
  logic [7:0] dout, rdata, wdata;
  logic oe, rd_p, wr_p, txs, rxs;
  logic [1:0] rchan;
  logic [2:0] raddr;
  logic [3:0] irq_o, irq_oe, irq_i = 4'h0, drv = 4'h0;
  logic [3:0] tx_n = 4'hf, rx_n = 4'hf;
  int error_cnt = 0, checks_done = 0, wr_seen = 0, wr_exp = 0, cyc = 0;
  int rd_seen = 0, rd_exp = 0;

  always #2 clk = ~clk;

  qup_host_port dut_u (.core_clk_in(clk), .sys_rst_in(rst),
    .bus_style_in(style), .read_strobe_n_in(rd_n), .write_strobe_n_in(wr_n),
    .chan_a_select_n_in(cs_n[0]), .chan_b_select_n_in(cs_n[1]),
    .chan_c_select_n_in(cs_n[2]), .chan_d_select_n_in(cs_n[3]),
    .addr_in(addr), .data_in(din), .data_out(dout), .data_oe_out(oe),
    .chan_irq_out(irq_o), .chan_irq_oe_out(irq_oe),
    .tx_ready_summary_n_out(txs), .rx_ready_summary_n_out(rxs),
    .reg_rd_out(rd_p), .reg_wr_out(wr_p), .reg_chan_out(rchan),
    .reg_addr_out(raddr), .reg_wdata_out(wdata), .reg_rdata_in(rdata),
    .chan_irq_in(irq_i), .irq_output_drive_bit_in(drv),
    .tx_ready_n_in(tx_n), .rx_ready_n_in(rx_n));

  qup_regs_model regs_u (.core_clk_in(clk), .sys_rst_in(rst),
    .reg_wr_in(wr_p), .reg_chan_in(rchan), .reg_addr_in(raddr),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata));

  // ----------------------------------------------------------------------
  // Checking and ending
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (wr_p === 1'b1) wr_seen++;
    if (rd_p === 1'b1) rd_seen++;
    cyc++;
    // Whole run needs well under 2000 cycles
    if (cyc == 5000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  // One host access; a read compares the returned byte with d
  task automatic bus_op(input logic wr, input logic [1:0] ch,
                        input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    din <= wr ? d : ~d;
    if (style) begin
      cs_n <= ~(4'h1 << ch);
      if (wr) wr_n <= 1'b0;
      else rd_n <= 1'b0;
    end else begin
      cs_n <= {1'b1, ch, 1'b0};
      wr_n <= ~wr;
    end
    for (int n = 0; n < 8; n++) begin
      @(posedge clk);
      #1;
      if (!wr && oe === 1'b1) break;
    end
    if (!wr) cmp("read byte", d, dout);
    @(posedge clk);
    rd_n <= 1'b1;
    if (style) wr_n <= 1'b1;
    else cs_n[0] <= 1'b1;
    repeat (4) @(posedge clk);
    cs_n <= 4'hf;
    wr_n <= 1'b1;
    din <= ~d;
    #1;
    cmp("bus released", 8'h00, {7'h0, oe});
    if (wr) wr_exp++;
    else rd_exp++;
    cmp("write pulses", wr_exp[7:0], wr_seen[7:0]);
    cmp("read pulses", rd_exp[7:0], rd_seen[7:0]);
    cmp("channel", {6'h0, ch}, {6'h0, rchan});
    cmp("register", {5'h0, a}, {5'h0, raddr});
    if (wr) cmp("write byte", d, wdata);
  endtask : bus_op

  task automatic set_style(input logic s);
    @(posedge clk);
    style <= s;
    repeat (4) @(posedge clk);
  endtask : set_style

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_strobe();
    set_style(1'b1);
    for (int c = 0; c < 4; c++)
      bus_op(1'b1, c[1:0], 3'(7 - c), 8'h3c ^ 8'(c));
    for (int c = 0; c < 4; c++)
      bus_op(1'b0, c[1:0], 3'(7 - c), 8'h3c ^ 8'(c));
  endtask : t_strobe

  task automatic t_rw();
    set_style(1'b0);
    for (int c = 0; c < 4; c++)
      bus_op(1'b0, c[1:0], 3'(7 - c), 8'h3c ^ 8'(c));
    for (int c = 0; c < 4; c++)
      bus_op(1'b1, c[1:0], c[2:0], 8'ha0 + 8'(c));
    for (int c = 0; c < 4; c++)
      bus_op(1'b0, c[1:0], c[2:0], 8'ha0 + 8'(c));
  endtask : t_rw

  task automatic t_nosel();
    set_style(1'b1);
    @(posedge clk);
    wr_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (5) @(posedge clk);
    wr_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (5) @(posedge clk);
    cmp("unselected write", wr_exp[7:0], wr_seen[7:0]);
    cmp("unselected read", rd_exp[7:0], rd_seen[7:0]);
  endtask : t_nosel

  task automatic t_irq();
    set_style(1'b1);
    @(posedge clk);
    irq_i <= 4'ha;
    drv <= 4'h6;
    repeat (3) @(posedge clk);
    #1;
    cmp("irq level", 8'h0a, {4'h0, irq_o});
    cmp("irq enable", 8'h06, {4'h0, irq_oe});
    set_style(1'b0);
    @(posedge clk);
    irq_i <= 4'h4;
    repeat (3) @(posedge clk);
    #1;
    cmp("irq rw level", 8'h00, {4'h0, irq_o});
    cmp("irq rw enable", 8'h0f, {4'h0, irq_oe});
    @(posedge clk);
    irq_i <= 4'h0;
    repeat (3) @(posedge clk);
    #1;
    cmp("irq rw idle", 8'h0e, {4'h0, irq_oe});
  endtask : t_irq

  task automatic t_ready();
    for (int p = 0; p < 16; p++) begin
      @(posedge clk);
      tx_n <= p[3:0];
      rx_n <= ~p[3:0];
      repeat (3) @(posedge clk);
      #1;
      cmp("tx summary", {7'h0, &p[3:0]}, {7'h0, txs});
      cmp("rx summary", {7'h0, ~|p[3:0]}, {7'h0, rxs});
    end
  endtask : t_ready

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_strobe();
    t_rw();
    t_nosel();
    t_irq();
    t_ready();
    wrap_up();
  end
endmodule : tb

`default_nettype wire
